// ===== rtl/pmbus_telemetry_limits_addr.sv
// Management command logic: telemetry, limits, strap address, link port
`timescale 1ns/1ps
module pmbus_telemetry_limits_addr
  import pmbus_tl_pkg::*;
#(
  parameter int         MS_CYC     = MS_CYC_DEF,
  parameter int         BUS_ON_CYC = BUS_ON_DEF,
  parameter int         ADDR_CYC   = ADDR_DEF,
  parameter logic [6:0] ADDR_BASE  = ADDR_BASE_DEF // Arbitrary value
)(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        link_clk,
  input  wire logic        aux_bias_supply_ok,
  input  wire logic        hi_below_uvlo,
  input  wire logic        hi_present,
  input  wire logic [11:0] strap_mv,
  input  wire tele_type    meas,
  input  wire logic        req_valid,
  input  wire req_type     req,
  output logic             link_busy_r,
  output logic             rsp_valid_r,
  output resp_type         rsp_r,
  output logic [6:0]       bus_addr_r,
  output logic             bus_active_r,
  output logic             powertrain_active_r,
  output logic [15:0]      uvlo_level_r,
  output logic [15:0]      ovlo_recovery_r,
  output logic [5:0]       limit_flags_r,
  output logic             nvm_write_r
);

  if (MS_CYC < 2 || MS_CYC > 65535 || BUS_ON_CYC > 65535 ||
      ADDR_CYC < 1 || ADDR_CYC >= BUS_ON_CYC)
  begin : g_bad
    $error("Timing parameters out of range");
  end

  typedef struct packed {
    logic [3:0]  s1;
    logic [3:0]  s2;
    logic [3:0]  s3;
    logic [3:0]  f;
    logic [15:0] up_cnt;
    logic        addr_done;
    logic        bus_on;
    logic [6:0]  addr;
    logic [11:0] fast_cnt;
    logic [15:0] ms_pre;
    logic [6:0]  slow_ms;
    tele_type    tele;
    logic [15:0] ot_f;
    logic [15:0] ot_w;
    logic [15:0] ov_f;
    logic [15:0] ov_w;
    logic [15:0] oc_f;
    logic [15:0] oc_w;
    logic [15:0] ton;
    logic [15:0] pdis;
    logic [15:0] ovrec;
    logic [15:0] uvlvl;
    logic        op_on;
    pwr_type     seq;
    logic [7:0]  seq_ms;
    logic        active;
    logic        dirty;
    logic [1:0]  commit_ms;
    logic        nvm_stb;
    logic [5:0]  flags;
    logic        req_seen;
    resp_type    resp;
    logic        rsp_tog;
  } main_type;

  typedef struct packed {
    req_type  req;
    logic     req_tog;
    logic     s1;
    logic     s2;
    logic     s3;
    logic     f;
    logic     rsp_seen;
    logic     busy;
    logic     rsp_valid;
    resp_type rsp;
  } link_type;

  main_type st_r;
  main_type st_nxt;
  link_type lk_r;
  link_type lk_nxt;

  // Strap millivolts to band index
  function automatic logic [3:0] strap_band(input logic [11:0] mv);
    int idx;
    idx = (int'(mv) * 1000) / BAND_UV;
    if (idx > ADDR_COUNT - 1)
      idx = ADDR_COUNT - 1;
    return 4'(idx);
  endfunction

  // Limit, threshold, start delay and protection disable commands
  function automatic logic is_limit(input logic [7:0] c);
    return c == CMD_OT_FAULT || c == CMD_OT_WARN || c == CMD_OV_FAULT ||
           c == CMD_OV_WARN || c == CMD_OC_FAULT || c == CMD_OC_WARN ||
           c == CMD_STARTUP_EXTRA_DELAY || c == CMD_PROT_DIS;
  endfunction

  logic        bias;
  logic        below;
  logic        fast_tick;
  logic        ms_tick;
  logic        slow_tick;
  logic        new_req;
  logic        wr_ok;
  logic [7:0]  ton_ms;
  logic [31:0] rec_full;

  always_comb
  begin
    st_nxt = st_r;
    bias = st_r.f[0];
    below = st_r.f[1];
    st_nxt.s1 = {lk_r.req_tog, hi_present, hi_below_uvlo,
                 aux_bias_supply_ok};
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    st_nxt.f = (st_r.s2 & st_r.s3) | (st_r.f & (st_r.s2 | st_r.s3));
    // Bias-up timing, strap capture, bus enable
    if (!bias)
    begin
      st_nxt.up_cnt = '0;
      st_nxt.bus_on = st_r.bus_on && st_r.f[2];
    end
    else
    begin
      if (st_r.up_cnt != 16'(BUS_ON_CYC - 1))
        st_nxt.up_cnt = st_r.up_cnt + 16'd1;
      else
        st_nxt.bus_on = 1'b1;
      if (!st_r.addr_done && st_r.up_cnt == 16'(ADDR_CYC - 1))
      begin
        st_nxt.addr = ADDR_BASE + {3'b000, strap_band(strap_mv)};
        st_nxt.addr_done = 1'b1;
      end
    end
    // Refresh ticks
    fast_tick = st_r.fast_cnt == 12'(FAST_CYC - 1);
    st_nxt.fast_cnt = fast_tick ? '0 : st_r.fast_cnt + 12'd1;
    ms_tick = st_r.ms_pre == 16'(MS_CYC - 1);
    st_nxt.ms_pre = ms_tick ? '0 : st_r.ms_pre + 16'd1;
    slow_tick = ms_tick && st_r.slow_ms == 7'(SLOW_MS - 1);
    if (ms_tick)
      st_nxt.slow_ms = slow_tick ? '0 : st_r.slow_ms + 7'd1;
    if (fast_tick)
    begin
      st_nxt.tele.hi_v = meas.hi_v;
      st_nxt.tele.hi_i = meas.hi_i;
      st_nxt.tele.lo_i = meas.lo_i;
      st_nxt.tele.lo_v = st_r.active ? meas.lo_v : SENT_LO_V;
    end
    if (slow_tick)
    begin
      st_nxt.tele.lo_r = meas.lo_r;
      st_nxt.tele.temp = st_r.active ? meas.temp : SENT_TEMP;
    end
    if (!bias && !st_r.f[2])
      st_nxt.tele = '0;
    // Power train sequencing
    ton_ms = (st_r.ton > 16'(TON_MAX_MS)) ? 8'(TON_MAX_MS) : st_r.ton[7:0];
    unique case (st_r.seq)
      PW_OFF:
      begin
        st_nxt.active = 1'b0;
        st_nxt.seq_ms = '0;
        if (st_r.op_on && !below)
          st_nxt.seq = PW_WAIT;
      end
      PW_WAIT:
        if (!st_r.op_on || below)
          st_nxt.seq = PW_OFF;
        else if (st_r.seq_ms == 8'(UVLO_DLY_MS) + ton_ms)
        begin
          st_nxt.seq = PW_ON;
          st_nxt.active = 1'b1;
        end
        else if (ms_tick)
          st_nxt.seq_ms = st_r.seq_ms + 8'd1;
      PW_ON:
        if (!st_r.op_on || below)
        begin
          st_nxt.seq = PW_OFF;
          st_nxt.active = 1'b0;
        end
    endcase
    // Commit to nonvolatile storage after changes while disabled
    st_nxt.nvm_stb = 1'b0;
    if (st_r.dirty)
    begin
      if (st_r.op_on)
        st_nxt.commit_ms = '0;
      else if (st_r.commit_ms == 2'(COMMIT_MS))
      begin
        st_nxt.nvm_stb = 1'b1;
        st_nxt.dirty = 1'b0;
      end
      else if (ms_tick)
        st_nxt.commit_ms = st_r.commit_ms + 2'd1;
    end
    // Derived protection levels
    rec_full = 32'(st_r.ov_f) * 32'(RECOV_NUM) / 32'(RECOV_DEN);
    st_nxt.ovrec = rec_full[15:0];
    st_nxt.uvlvl = st_r.pdis[PDIS_UV_BIT] ? UV_PRESET : UV_NORMAL;
    st_nxt.flags = {
      $signed(st_r.tele.temp) >= $signed(st_r.ot_f),
      $signed(st_r.tele.temp) >= $signed(st_r.ot_w),
      $signed(st_r.tele.hi_i) >= $signed(st_r.oc_f),
      $signed(st_r.tele.hi_i) >= $signed(st_r.oc_w),
      st_r.tele.hi_v >= st_r.ov_f,
      st_r.tele.hi_v >= st_r.ov_w};
    // Command execution
    new_req = st_r.f[3] != st_r.req_seen;
    wr_ok = bias && below && !st_r.op_on && !st_r.active;
    if (new_req)
    begin
      st_nxt.req_seen = st_r.f[3];
      st_nxt.rsp_tog = ~st_r.rsp_tog;
      st_nxt.resp = '{nack: 1'b0, rdata: 16'h0000};
      if (!st_r.bus_on)
        st_nxt.resp.nack = 1'b1;
      else if (lk_r.req.write)
      begin
        if (is_limit(lk_r.req.code) && !wr_ok)
          st_nxt.resp.nack = 1'b1;
        else
        begin
          if (is_limit(lk_r.req.code))
          begin
            st_nxt.dirty = 1'b1;
            st_nxt.commit_ms = '0;
          end
          unique case (lk_r.req.code)
            CMD_OPERATION:
              if (bias)
                st_nxt.op_on = lk_r.req.wdata[OP_ON_BIT];
              else
                st_nxt.resp.nack = 1'b1;
            CMD_OT_FAULT:  st_nxt.ot_f = lk_r.req.wdata;
            CMD_OT_WARN:   st_nxt.ot_w = lk_r.req.wdata;
            CMD_OV_FAULT:  st_nxt.ov_f = lk_r.req.wdata;
            CMD_OV_WARN:   st_nxt.ov_w = lk_r.req.wdata;
            CMD_OC_FAULT:  st_nxt.oc_f = lk_r.req.wdata;
            CMD_OC_WARN:   st_nxt.oc_w = lk_r.req.wdata;
            CMD_STARTUP_EXTRA_DELAY: st_nxt.ton = lk_r.req.wdata;
            CMD_PROT_DIS:  st_nxt.pdis = lk_r.req.wdata;
            default:       st_nxt.resp.nack = 1'b1;
          endcase
        end
      end
      else
        unique case (lk_r.req.code)
          CMD_OPERATION: st_nxt.resp.rdata = 16'({st_r.op_on, 7'h00});
          CMD_OT_FAULT:  st_nxt.resp.rdata = st_r.ot_f;
          CMD_OT_WARN:   st_nxt.resp.rdata = st_r.ot_w;
          CMD_OV_FAULT:  st_nxt.resp.rdata = st_r.ov_f;
          CMD_OV_WARN:   st_nxt.resp.rdata = st_r.ov_w;
          CMD_OC_FAULT:  st_nxt.resp.rdata = st_r.oc_f;
          CMD_OC_WARN:   st_nxt.resp.rdata = st_r.oc_w;
          CMD_STARTUP_EXTRA_DELAY: st_nxt.resp.rdata = st_r.ton;
          CMD_PROT_DIS:  st_nxt.resp.rdata = st_r.pdis;
          CMD_RD_HI_V:   st_nxt.resp.rdata = st_r.tele.hi_v;
          CMD_RD_HI_I:   st_nxt.resp.rdata = st_r.tele.hi_i;
          CMD_RD_LO_V:   st_nxt.resp.rdata = st_r.tele.lo_v;
          CMD_RD_LO_I:   st_nxt.resp.rdata = st_r.tele.lo_i;
          CMD_RD_TEMP:   st_nxt.resp.rdata = st_r.tele.temp;
          CMD_RD_LO_R:   st_nxt.resp.rdata = st_r.tele.lo_r;
          default:       st_nxt.resp.nack = 1'b1;
        endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_r <= '0;
      st_r.ot_f <= OT_DEF;
      st_r.ot_w <= OT_DEF;
      st_r.ov_f <= OV_DEF;
      st_r.ov_w <= OV_DEF;
      st_r.oc_f <= OC_DEF;
      st_r.oc_w <= OC_DEF;
      st_r.ton <= TON_DEF;
      st_r.pdis <= PDIS_DEF;
      st_r.uvlvl <= UV_NORMAL;
      st_r.seq <= PW_OFF;
    end
    else
      st_r <= st_nxt;
  end

  // Link side: hold request, toggle across, wait for answer toggle
  always_comb
  begin
    lk_nxt = lk_r;
    lk_nxt.s1 = st_r.rsp_tog;
    lk_nxt.s2 = lk_r.s1;
    lk_nxt.s3 = lk_r.s2;
    lk_nxt.f = (lk_r.s2 & lk_r.s3) | (lk_r.f & (lk_r.s2 | lk_r.s3));
    lk_nxt.rsp_valid = 1'b0;
    if (lk_r.busy && lk_r.f != lk_r.rsp_seen)
    begin
      lk_nxt.rsp_seen = lk_r.f;
      lk_nxt.rsp = st_r.resp;
      lk_nxt.rsp_valid = 1'b1;
      lk_nxt.busy = 1'b0;
    end
    else if (!lk_r.busy && req_valid)
    begin
      lk_nxt.req = req;
      lk_nxt.req_tog = ~lk_r.req_tog;
      lk_nxt.busy = 1'b1;
    end
  end

  always_ff @(posedge link_clk or negedge rst_b)
  begin
    if (!rst_b)
      lk_r <= '0;
    else
      lk_r <= lk_nxt;
  end

  // No alert output: conditions are polled
  assign link_busy_r         = lk_r.busy;
  assign rsp_valid_r         = lk_r.rsp_valid;
  assign rsp_r               = lk_r.rsp;
  assign bus_addr_r          = st_r.addr;
  assign bus_active_r        = st_r.bus_on;
  assign powertrain_active_r = st_r.active;
  assign uvlo_level_r        = st_r.uvlvl;
  assign ovlo_recovery_r     = st_r.ovrec;
  assign limit_flags_r       = st_r.flags;
  assign nvm_write_r         = st_r.nvm_stb;

  chk_lo_v_sentinel: assert property (@(posedge clk) disable iff (!rst_b)
    fast_tick && !st_r.active && (bias || st_r.f[2])
    |=> st_r.tele.lo_v == SENT_LO_V)
    else $error("Low-side voltage sentinel missing");
  chk_temp_sentinel: assert property (@(posedge clk) disable iff (!rst_b)
    slow_tick && !st_r.active && (bias || st_r.f[2])
    |=> st_r.tele.temp == SENT_TEMP)
    else $error("Temperature sentinel missing");
  chk_fast_refresh: assert property (@(posedge clk) disable iff (!rst_b)
    $changed(st_r.tele.hi_v) && (bias || st_r.f[2])
    |-> $past(st_r.fast_cnt) == 12'(FAST_CYC - 1))
    else $error("High-side voltage changed off tick");
  chk_limit_refused: assert property (@(posedge clk) disable iff (!rst_b)
    new_req && st_r.bus_on && lk_r.req.write &&
    lk_r.req.code == CMD_OV_FAULT && !wr_ok
    |=> st_r.resp.nack && $stable(st_r.ov_f) ##1 $stable(st_r.ovrec))
    else $error("Refused limit write took effect");
  chk_recovery_lvl: assert property (@(posedge clk) disable iff (!rst_b)
    new_req && wr_ok && st_r.bus_on && lk_r.req.write &&
    lk_r.req.code == CMD_OV_FAULT
    |=> ##1 st_r.ovrec ==
        16'(32'(st_r.ov_f) * 32'(RECOV_NUM) / 32'(RECOV_DEN)))
    else $error("Recovery level not derived");
  chk_addr_fixed: assert property (@(posedge clk) disable iff (!rst_b)
    st_r.addr_done |=> st_r.addr_done && $stable(st_r.addr))
    else $error("Strap address changed");
  chk_bus_gate: assert property (@(posedge clk) disable iff (!rst_b)
    new_req && !st_r.bus_on |=> st_r.resp.nack)
    else $error("Answered before bus active");
  chk_startup_extra_delay: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(st_r.active)
    |-> $past(st_r.seq_ms) == 8'(UVLO_DLY_MS) + $past(ton_ms))
    else $error("Start delay wrong");
  chk_uv_preset: assert property (@(posedge clk) disable iff (!rst_b)
    st_r.pdis[PDIS_UV_BIT] |=> st_r.uvlvl == UV_PRESET)
    else $error("Undervoltage level not preset");
  chk_link_answer: assert property (@(posedge link_clk) disable iff (!rst_b)
    lk_r.rsp_valid |-> !lk_r.busy ##1 !lk_r.rsp_valid)
    else $error("Answer pulse longer than one cycle");

  cov_read_ok: cover property (@(posedge link_clk) disable iff (!rst_b)
    lk_r.rsp_valid && !lk_r.rsp.nack);
  cov_commit: cover property (@(posedge clk) disable iff (!rst_b)
    st_r.nvm_stb);
  cov_power_on: cover property (@(posedge clk) disable iff (!rst_b)
    $rose(st_r.active));

endmodule

// ===== rtl/pmbus_tl_pkg.sv
// Constants, codes and carrier types of the management command logic
package pmbus_tl_pkg;
  localparam int CLK_HZ      = 20_000_000;
  localparam int CYC_PER_US  = CLK_HZ / 1_000_000;
  localparam int FAST_US     = 100;
  localparam int FAST_CYC    = FAST_US * CYC_PER_US;
  localparam int MS_CYC_DEF  = CLK_HZ / 1000;
  localparam int BUS_ON_US   = 1500;
  localparam int BUS_ON_DEF  = BUS_ON_US * CYC_PER_US;
  localparam int ADDR_REG_US = 1000;
  localparam int ADDR_DEF    = ADDR_REG_US * CYC_PER_US;
  localparam int SLOW_MS     = 100;
  localparam int UVLO_DLY_MS = 20;
  localparam int COMMIT_MS   = 3;
  localparam int TON_MAX_MS  = 100;
  localparam int BAND_UV     = 206_250;
  localparam int ADDR_COUNT  = 16;
  localparam int RECOV_NUM   = 97;
  localparam int RECOV_DEN   = 100;
  localparam int OP_ON_BIT   = 7;
  localparam int PDIS_UV_BIT = 0;
  // Command codes
  localparam logic [7:0] CMD_OPERATION = 8'h01;
  localparam logic [7:0] CMD_OT_FAULT  = 8'h4f;
  localparam logic [7:0] CMD_OT_WARN   = 8'h51;
  localparam logic [7:0] CMD_OV_FAULT  = 8'h55;
  localparam logic [7:0] CMD_OV_WARN   = 8'h57;
  localparam logic [7:0] CMD_OC_FAULT  = 8'h5b;
  localparam logic [7:0] CMD_OC_WARN   = 8'h5d;
  localparam logic [7:0] CMD_STARTUP_EXTRA_DELAY = 8'h60;
  localparam logic [7:0] CMD_RD_HI_V   = 8'h88;
  localparam logic [7:0] CMD_RD_HI_I   = 8'h89;
  localparam logic [7:0] CMD_RD_LO_V   = 8'h8b;
  localparam logic [7:0] CMD_RD_LO_I   = 8'h8c;
  localparam logic [7:0] CMD_RD_TEMP   = 8'h8d;
  localparam logic [7:0] CMD_RD_LO_R   = 8'hd4;
  localparam logic [7:0] CMD_PROT_DIS  = 8'hd7;
  // Factory defaults and fixed values
  localparam logic [15:0] OV_DEF     = 16'h0294;
  localparam logic [15:0] OC_DEF     = 16'h0d48;
  localparam logic [15:0] OT_DEF     = 16'h007d;
  localparam logic [15:0] TON_DEF    = 16'h0000;
  localparam logic [15:0] PDIS_DEF   = 16'h0000;
  localparam logic [15:0] UV_NORMAL  = 16'h0118;
  localparam logic [15:0] UV_PRESET  = 16'h0294;
  localparam logic [15:0] SENT_LO_V  = 16'hf448;
  localparam logic [15:0] SENT_TEMP  = 16'hfeef;
  localparam logic [6:0]  ADDR_BASE_DEF = 7'h40;

  typedef enum logic [1:0] {
    PW_OFF  = 2'b00,
    PW_WAIT = 2'b01,
    PW_ON   = 2'b10
  } pwr_type;

  typedef struct packed {
    logic        write;
    logic [7:0]  code;
    logic [15:0] wdata;
  } req_type;

  typedef struct packed {
    logic        nack;
    logic [15:0] rdata;
  } resp_type;

  typedef struct packed {
    logic [15:0] hi_v;
    logic [15:0] hi_i;
    logic [15:0] lo_v;
    logic [15:0] lo_i;
    logic [15:0] temp;
    logic [15:0] lo_r;
  } tele_type;
endpackage

// ===== verif/pmbus_host_model.sv
// Host model driving the request and answer link port
`timescale 1ns/1ps
module pmbus_host_model
  import pmbus_tl_pkg::*;
(
  input  wire logic     link_clk,
  output logic          req_valid,
  output req_type       req,
  input  wire logic     link_busy_r,
  input  wire logic     rsp_valid_r,
  input  wire resp_type rsp_r
);
  initial
  begin
    req_valid = 1'b0;
    req       = '0;
  end

  // Request held until taken; answer sampled while it stands
  task automatic xfer(input logic w, input logic [7:0] c,
                      input logic [15:0] d, output resp_type r);
    int n;
    begin
      n = 0;
      r = 'x;
      @(negedge link_clk);
      req_valid = 1'b1;
      req       = '{write: w, code: c, wdata: d};
      while (link_busy_r !== 1'b0)
        @(negedge link_clk);
      @(negedge link_clk);
      req_valid = 1'b0;
      // Released lines show a changed pattern, not the old request
      req       = ~req;
      while (rsp_valid_r !== 1'b1 && n < 200)
      begin
        @(negedge link_clk);
        n++;
      end
      if (rsp_valid_r === 1'b1)
        r = rsp_r;
    end
  endtask
endmodule

// ===== verif/pmbus_telemetry_limits_addr_tb_top.sv
// Self-checking bench for the management command logic
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) \
    begin \
      miscompares++; \
      $display("mismatch at %0t: got %h want %h", $time, got, exp); \
    end \
  end
module pmbus_telemetry_limits_addr_tb_top
  import pmbus_tl_pkg::*;
;
  logic        clk;
  logic        rst_b;
  logic        link_clk;
  logic        aux_bias_supply_ok;
  logic        hi_below_uvlo;
  logic        hi_present;
  logic [11:0] strap_mv;
  tele_type    meas;
  logic        req_valid;
  req_type     req;
  logic        link_busy_r;
  logic        rsp_valid_r;
  resp_type    rsp_r;
  logic [6:0]  bus_addr_r;
  logic        bus_active_r;
  logic        powertrain_active_r;
  logic [15:0] uvlo_level_r;
  logic [15:0] ovlo_recovery_r;
  logic [5:0]  limit_flags_r;
  logic        nvm_write_r;
  int          tests_run;
  int          miscompares;

  pmbus_telemetry_limits_addr #(
    .MS_CYC     (20),
    .BUS_ON_CYC (60),
    .ADDR_CYC   (40)
  ) dut (
    .clk                 (clk),
    .rst_b               (rst_b),
    .link_clk            (link_clk),
    .aux_bias_supply_ok  (aux_bias_supply_ok),
    .hi_below_uvlo       (hi_below_uvlo),
    .hi_present          (hi_present),
    .strap_mv            (strap_mv),
    .meas                (meas),
    .req_valid           (req_valid),
    .req                 (req),
    .link_busy_r         (link_busy_r),
    .rsp_valid_r         (rsp_valid_r),
    .rsp_r               (rsp_r),
    .bus_addr_r          (bus_addr_r),
    .bus_active_r        (bus_active_r),
    .powertrain_active_r (powertrain_active_r),
    .uvlo_level_r        (uvlo_level_r),
    .ovlo_recovery_r     (ovlo_recovery_r),
    .limit_flags_r       (limit_flags_r),
    .nvm_write_r         (nvm_write_r)
  );

  pmbus_host_model host (
    .link_clk    (link_clk),
    .req_valid   (req_valid),
    .req         (req),
    .link_busy_r (link_busy_r),
    .rsp_valid_r (rsp_valid_r),
    .rsp_r       (rsp_r)
  );

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial
  begin
    link_clk = 1'b0;
    #3.3;
    forever #7.5 link_clk = ~link_clk;
  end

  task automatic complete_run;
    $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic rd(input logic [7:0] c, input logic n, input logic [15:0] d);
    resp_type r;
    host.xfer(1'b0, c, 16'h0000, r);
    `CHK(r.nack, n)
    if (n == 1'b0)
      `CHK(r.rdata, d)
  endtask

  task automatic wr(input logic [7:0] c, input logic [15:0] d, input logic n);
    resp_type r;
    host.xfer(1'b1, c, d, r);
    `CHK(r.nack, n)
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Cuts a hang short
  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares++;
    complete_run();
  end

  initial
  begin
    logic [7:0]  codes [8];
    logic [15:0] defs [8];
    int          n;
    codes = '{CMD_OT_FAULT, CMD_OT_WARN, CMD_OV_FAULT, CMD_OV_WARN,
              CMD_OC_FAULT, CMD_OC_WARN, CMD_STARTUP_EXTRA_DELAY, CMD_PROT_DIS};
    defs  = '{OT_DEF, OT_DEF, OV_DEF, OV_DEF, OC_DEF, OC_DEF, TON_DEF,
              PDIS_DEF};
    tests_run          = 0;
    miscompares        = 0;
    rst_b              = 1'b0;
    aux_bias_supply_ok = 1'b1;
    hi_below_uvlo      = 1'b1;
    hi_present         = 1'b1;
    strap_mv           = 12'h03e8;
    meas = '{hi_v: 16'h0100, hi_i: 16'h0200, lo_v: 16'h005a,
             lo_i: 16'hfff0, temp: 16'h0030, lo_r: 16'h0064};
    wait_clk(16);
    rst_b = 1'b1;
    rd(CMD_RD_HI_V, 1'b1, 16'h0000);
    wait_clk(30);
    `CHK(bus_addr_r, 7'h00)
    wait_clk(20);
    `CHK(bus_active_r, 1'b0)
    `CHK(bus_addr_r, ADDR_BASE_DEF + 7'h04)
    strap_mv = 12'h0ce4;
    wait_clk(30);
    `CHK(bus_active_r, 1'b1)
    `CHK(bus_addr_r, ADDR_BASE_DEF + 7'h04)
    for (int i = 0; i < 8; i++)
      rd(codes[i], 1'b0, defs[i]);
    wr(CMD_RD_HI_V, 16'h1234, 1'b1);
    wait_clk(2200);
    rd(CMD_RD_HI_V, 1'b0, 16'h0100);
    rd(CMD_RD_HI_I, 1'b0, 16'h0200);
    rd(CMD_RD_LO_V, 1'b0, SENT_LO_V);
    rd(CMD_RD_LO_I, 1'b0, 16'hfff0);
    rd(CMD_RD_TEMP, 1'b0, SENT_TEMP);
    rd(CMD_RD_LO_R, 1'b0, 16'h0064);
    wait_clk(1);
    meas.hi_v = 16'h0150;
    meas.hi_i = OC_DEF;
    wait_clk(2100);
    rd(CMD_RD_HI_V, 1'b0, 16'h0150);
    `CHK(limit_flags_r[3:0], 4'b1100)
    wr(CMD_OV_FAULT, 16'h0200, 1'b0);
    rd(CMD_OV_FAULT, 1'b0, 16'h0200);
    `CHK(ovlo_recovery_r, 16'h01f0)
    n = 0;
    while (nvm_write_r !== 1'b1 && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    `CHK(n >= 30 && n <= 90, 1'b1)
    hi_below_uvlo = 1'b0;
    wait_clk(5);
    wr(CMD_OC_WARN, 16'h0100, 1'b1);
    rd(CMD_OC_WARN, 1'b0, OC_DEF);
    wr(CMD_OV_FAULT, 16'h0100, 1'b1);
    `CHK(ovlo_recovery_r, 16'h01f0)
    wait_clk(1);
    hi_below_uvlo = 1'b1;
    wait_clk(5);
    wr(CMD_PROT_DIS, 16'h0001, 1'b0);
    wait_clk(5);
    `CHK(uvlo_level_r, UV_PRESET)
    wr(CMD_PROT_DIS, 16'h0000, 1'b0);
    wait_clk(5);
    `CHK(uvlo_level_r, UV_NORMAL)
    wr(CMD_STARTUP_EXTRA_DELAY, 16'h0005, 1'b0);
    wait_clk(120); // Kept disabled while limits commit
    wr(CMD_OPERATION, 16'h0080, 1'b0);
    rd(CMD_OPERATION, 1'b0, 16'h0080);
    `CHK(powertrain_active_r, 1'b0)
    wait_clk(1);
    hi_below_uvlo = 1'b0;
    n = 0;
    while (powertrain_active_r !== 1'b1 && n < 700)
    begin
      @(negedge clk);
      n++;
    end
    `CHK(n >= 470 && n <= 545, 1'b1)
    wr(CMD_OT_WARN, 16'h0050, 1'b1);
    wait_clk(2100);
    rd(CMD_RD_LO_V, 1'b0, 16'h005a);
    rd(CMD_RD_TEMP, 1'b0, 16'h0030);
    wait_clk(1);
    aux_bias_supply_ok = 1'b0;
    wait_clk(10);
    `CHK(bus_active_r, 1'b1)
    rd(CMD_RD_HI_V, 1'b0, 16'h0150);
    wr(CMD_OPERATION, 16'h0000, 1'b1);
    wr(CMD_OT_WARN, 16'h0050, 1'b1);
    wait_clk(1);
    hi_present = 1'b0;
    wait_clk(10);
    `CHK(bus_active_r, 1'b0)
    rd(CMD_RD_HI_V, 1'b1, 16'h0000);
    complete_run();
  end
endmodule
